// ==== src/gpd_dual_port.sv ====
// Implementation choices: the address map and the APB register port.
`default_nettype none

module gpd_dual_port
  import gpd_pkg::*;
#(
  parameter int P1W = 8,
  parameter int P2W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  // APB slave port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Read-modify-write flag, held with the read request.
  input wire logic rmwAccess,
  // Stop or watch mode is active while high.
  input wire logic standbyMode,
  // Port 1 pins and peripheral sharing.
  input wire logic [P1W-1:0] pinIn1,
  output logic [P1W-1:0] pinOut1,
  output logic [P1W-1:0] pinOe1,
  output logic [P1W-1:0] pullEn1,
  input wire logic [P1W-1:0] perOe1,
  input wire logic [P1W-1:0] perOut1,
  output logic [P1W-1:0] perIn1,
  // Port 2 pins and peripheral sharing.
  input wire logic [P2W-1:0] pinIn2,
  output logic [P2W-1:0] pinOut2,
  output logic [P2W-1:0] pinOe2,
  output logic [P2W-1:0] pullEn2,
  input wire logic [P2W-1:0] perOe2,
  input wire logic [P2W-1:0] perOut2,
  output logic [P2W-1:0] perIn2,
  // Comparator analog input enables for the two shared port 2 pins.
  output logic [1:0] cmpInEn
);

  // The fixed wake and comparator pin positions need these widths.
  if (P1W < 5 || P1W > 8 || P2W < 2 || P2W > 8) begin : g_chk
    $error("gpd_dual_port: unsupported port width");
  end

  // Software-visible registers.
  logic [P1W-1:0] p1Latch; // Port 1 output latch.
  logic [P1W-1:0] p1Dir; // Port 1 direction, one is output.
  logic [P1W-1:0] p1Pull; // Port 1 pull-up enables.
  logic [P2W-1:0] p2Latch; // Port 2 output latch.
  logic [P2W-1:0] p2Dir; // Port 2 direction, one is output.
  logic [P2W-1:0] p2Pull; // Port 2 pull-up enables.
  gpd_ctrl_t ctrl; // Standby, comparator and wake controls.

  // Standby tracking.
  logic standbyPrev; // Standby level one cycle ago.
  logic floatActive; // Pins are floated for the current standby.

  // Masks cut to the port widths.
  wire logic [P1W-1:0] p1PullMask = GPD_P1_PULL_MASK[P1W-1:0];
  wire logic [P2W-1:0] p2PullMask = GPD_P2_PULL_MASK[P2W-1:0];
  wire logic [P1W-1:0] p1OdMask = GPD_P1_OD_MASK[P1W-1:0];
  wire logic [P2W-1:0] p2OdMask = GPD_P2_OD_MASK[P2W-1:0];

  // Bus phase decode.
  wire logic setupPhase = psel & ~penable;
  wire logic accessPhase = psel & penable;
  wire logic hitP1Latch = (paddr == GPD_OFF_P1_LATCH);
  wire logic hitP1Dir = (paddr == GPD_OFF_P1_DIR);
  wire logic hitP1Pull = (paddr == GPD_OFF_P1_PULL);
  wire logic hitP2Latch = (paddr == GPD_OFF_P2_LATCH);
  wire logic hitP2Dir = (paddr == GPD_OFF_P2_DIR);
  wire logic hitP2Pull = (paddr == GPD_OFF_P2_PULL);
  wire logic hitCtrl = (paddr == GPD_OFF_CTRL);
  wire logic hitAny = hitP1Latch | hitP1Dir | hitP1Pull | hitP2Latch |
                      hitP2Dir | hitP2Pull | hitCtrl;
  wire logic wrEn = accessPhase & pwrite & hitAny;

  // The slave never inserts wait states; read data is captured in setup.
  assign pready = 1'b1;
  // Unmapped offsets answer with an error in the access phase.
  assign pslverr = accessPhase & ~hitAny;

  // Input gating in floated standby: wake pins stay open when armed and selected.
  wire logic wakeArm = ctrl.extIrqEn;
  // Each bit is widened before the shift so the upper wake pin survives.
  wire logic [P1W-1:0] p1Keep =
    (P1W'(wakeArm & ctrl.sel10) << GPD_P1_WAKE_A) |
    (P1W'(wakeArm & ctrl.sel14) << GPD_P1_WAKE_B);
  wire logic [P1W-1:0] p1InOpen = {P1W{~floatActive}} | p1Keep;
  wire logic [P2W-1:0] p2InOpen = {P2W{~floatActive}};
  // A blocked input reads as low, which avoids leakage from an open pin.
  wire logic [P1W-1:0] p1Level = pinIn1 & p1InOpen;
  wire logic [P2W-1:0] p2Level = pinIn2 & p2InOpen;

  // Pin drive: the peripheral wins over the latch when it enables output.
  wire logic [P1W-1:0] p1Val = (perOe1 & perOut1) |
                               (~perOe1 & p1Latch);
  wire logic [P2W-1:0] p2Val = (perOe2 & perOut2) |
                               (~perOe2 & p2Latch);
  wire logic [P1W-1:0] p1Want = (p1Dir | perOe1);
  wire logic [P2W-1:0] p2Want = (p2Dir | perOe2);
  // Open-drain pins only sink; a one releases the pin.
  wire logic [P1W-1:0] next_pinOe1 = p1Want & ~(p1OdMask & p1Val) &
                                     {P1W{~floatActive}};
  wire logic [P2W-1:0] next_pinOe2 = p2Want & ~(p2OdMask & p2Val) &
                                     {P2W{~floatActive}};
  // Pull-ups drop whenever the pin is being driven low.
  wire logic [P1W-1:0] next_pullEn1 = p1Pull & p1PullMask &
                                      ~(next_pinOe1 & ~p1Val);
  wire logic [P2W-1:0] next_pullEn2 = p2Pull & p2PullMask &
                                      ~(next_pinOe2 & ~p2Val);

  // Read selection: READ_MODIFY_WRITE_ACCESS or a port-owned output returns the latch.
  wire logic [P1W-1:0] p1LatchSel = {P1W{rmwAccess}} |
                                    (p1Dir & ~perOe1);
  wire logic [P2W-1:0] p2LatchSel = {P2W{rmwAccess}} |
                                    (p2Dir & ~perOe2);
  // Other bits read the gated pin level, peripheral driven or not.
  wire logic [P1W-1:0] p1ReadVal = (p1LatchSel & p1Latch) |
                                   (~p1LatchSel & p1Level);
  wire logic [P2W-1:0] p2ReadVal = (p2LatchSel & p2Latch) |
                                   (~p2LatchSel & p2Level);

  // Read data mux; unused upper bits read as zero.
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hitP1Latch) begin
      next_prdata[P1W-1:0] = p1ReadVal;
    end else if (hitP1Dir) begin
      next_prdata[P1W-1:0] = p1Dir;
    end else if (hitP1Pull) begin
      next_prdata[P1W-1:0] = p1Pull & p1PullMask;
    end else if (hitP2Latch) begin
      next_prdata[P2W-1:0] = p2ReadVal;
    end else if (hitP2Dir) begin
      next_prdata[P2W-1:0] = p2Dir;
    end else if (hitP2Pull) begin
      next_prdata[P2W-1:0] = p2Pull & p2PullMask;
    end else if (hitCtrl) begin
      next_prdata[GPD_CTRL_WIDTH-1:0] = ctrl;
    end
  end

  // Read data is captured at the setup edge and held through access.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Port 1 registers. A latch write lands even on input pins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p1Latch <= GPD_RST_LATCH[P1W-1:0];
      p1Dir <= GPD_RST_DIR[P1W-1:0];
      p1Pull <= GPD_RST_PULL[P1W-1:0];
    end else if (wrEn) begin
      if (hitP1Latch) begin
        p1Latch <= pwdata[P1W-1:0];
      end
      if (hitP1Dir) begin
        p1Dir <= pwdata[P1W-1:0];
      end
      if (hitP1Pull) begin
        p1Pull <= pwdata[P1W-1:0];
      end
    end
  end

  // Port 2 registers, same behaviour as port 1.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p2Latch <= GPD_RST_LATCH[P2W-1:0];
      p2Dir <= GPD_RST_DIR[P2W-1:0];
      p2Pull <= GPD_RST_PULL[P2W-1:0];
    end else if (wrEn) begin
      if (hitP2Latch) begin
        p2Latch <= pwdata[P2W-1:0];
      end
      if (hitP2Dir) begin
        p2Dir <= pwdata[P2W-1:0];
      end
      if (hitP2Pull) begin
        p2Pull <= pwdata[P2W-1:0];
      end
    end
  end

  // Control register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= gpd_ctrl_t'(GPD_RST_CTRL);
    end else if (wrEn && hitCtrl) begin
      ctrl <= gpd_ctrl_t'(pwdata[GPD_CTRL_WIDTH-1:0]);
    end
  end

  // The float choice is taken at standby entry and kept until exit, so a
  // later write to the float bit cannot release pins in mid-standby.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      standbyPrev <= 1'b0;
      floatActive <= 1'b0;
    end else begin
      standbyPrev <= standbyMode;
      if (!standbyMode) begin
        floatActive <= 1'b0;
      end else if (!standbyPrev) begin
        floatActive <= ctrl.floatSel;
      end
    end
  end

  // Pin-side outputs are registered, one cycle behind their causes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut1 <= '0;
      pinOe1 <= '0;
      pullEn1 <= '0;
      perIn1 <= '0;
      pinOut2 <= '0;
      pinOe2 <= '0;
      pullEn2 <= '0;
      perIn2 <= '0;
    end else begin
      pinOut1 <= p1Val;
      pinOe1 <= next_pinOe1;
      pullEn1 <= next_pullEn1;
      perIn1 <= p1Level;
      pinOut2 <= p2Val;
      pinOe2 <= next_pinOe2;
      pullEn2 <= next_pullEn2;
      perIn2 <= p2Level;
    end
  end

  // Comparator inputs ignore port data and direction entirely.
  assign cmpInEn = {2{~ctrl.cmpDisable}};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Checks on the behaviour above.
  dir_reset_a: assert property (
    @(posedge clk) $rose(rst_n) |-> (p1Dir == '0 && p2Dir == '0))
    else $error("direction not cleared by reset");

  input_undriven_a: assert property (
    1'b1 |=> (pinOe1 & $past(~p1Dir & ~perOe1)) == '0)
    else $error("input pin driven");

  out_follows_a: assert property (
    1'b1 |=> ((pinOut1 ^ $past(p1Latch)) & $past(p1Dir & ~perOe1)) == '0)
    else $error("output pin does not follow latch");

  out_enable_a: assert property (
    !floatActive |=> ((pinOe1 ^ $past(p1Dir)) &
                      $past(p1Dir & ~p1OdMask)) == '0)
    else $error("output pin not enabled");

  per_override_a: assert property (
    1'b1 |=> ((pinOut2 ^ $past(perOut2)) & $past(perOe2)) == '0)
    else $error("peripheral output not on pin");

  od_release_a: assert property (
    (pinOe2 & pinOut2 & p2OdMask) == '0 &&
    (pinOe1 & pinOut1 & p1OdMask) == '0)
    else $error("open drain pin driven high");

  float_pins_a: assert property (
    floatActive |=> (pinOe1 == '0 && pinOe2 == '0))
    else $error("pins driven while floated");

  float_entry_a: assert property (
    $rose(standbyMode) && !ctrl.floatSel |=> !floatActive [*3])
    else $error("pins floated with float bit clear");

  pull_low_a: assert property (
    (pullEn1 & pinOe1 & ~pinOut1) == '0 &&
    (pullEn2 & pinOe2 & ~pinOut2) == '0)
    else $error("pull-up on a pin driving low");

  rmw_read_a: assert property (
    setupPhase && !pwrite && hitP1Latch && rmwAccess
    |=> prdata[P1W-1:0] == $past(p1Latch))
    else $error("READ_MODIFY_WRITE_ACCESS read did not return latch");

  pin_read_a: assert property (
    setupPhase && !pwrite && hitP2Latch && !rmwAccess
    |=> prdata[P2W-1:0] ==
        $past((p2Dir & ~perOe2 & p2Latch) | (~(p2Dir & ~perOe2) & p2Level)))
    else $error("plain read returned wrong source");

  cmp_disable_a: assert property (
    wrEn && hitCtrl && pwdata[GPD_CTRL_CMPDIS_POS]
    |=> cmpInEn == 2'h0 [*2])
    else $error("comparator input not disabled");

endmodule : gpd_dual_port

`default_nettype wire

// ==== inc/gpd_pkg.sv ====
`default_nettype none

// Shared constants and types for the dual general-purpose port.
package gpd_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] GPD_OFF_P1_LATCH = 8'h00;
  localparam logic [7:0] GPD_OFF_P1_DIR = 8'h04;
  localparam logic [7:0] GPD_OFF_P1_PULL = 8'h08;
  localparam logic [7:0] GPD_OFF_P2_LATCH = 8'h0c;
  localparam logic [7:0] GPD_OFF_P2_DIR = 8'h10;
  localparam logic [7:0] GPD_OFF_P2_PULL = 8'h14;
  localparam logic [7:0] GPD_OFF_CTRL = 8'h18;

  // Field positions inside the control register.
  localparam int GPD_CTRL_FLOAT_POS = 0;
  localparam int GPD_CTRL_CMPDIS_POS = 1;
  localparam int GPD_CTRL_EXTIRQ_POS = 2;
  localparam int GPD_CTRL_SEL10_POS = 3;
  localparam int GPD_CTRL_SEL14_POS = 4;
  localparam int GPD_CTRL_WIDTH = 5;

  // Reset values of the registers.
  localparam logic [7:0] GPD_RST_LATCH = 8'h00;
  localparam logic [7:0] GPD_RST_DIR = 8'h00;
  localparam logic [7:0] GPD_RST_PULL = 8'h00;
  localparam logic [4:0] GPD_RST_CTRL = 5'h00;

  // Pins that own a pull-up resistor and pins that are open drain.
  localparam logic [7:0] GPD_P1_PULL_MASK = 8'h9b;
  localparam logic [7:0] GPD_P2_PULL_MASK = 8'h03;
  localparam logic [7:0] GPD_P1_OD_MASK = 8'h00;
  localparam logic [7:0] GPD_P2_OD_MASK = 8'h0c;

  // Bit positions of the two wake-capable pins and the comparator pins.
  localparam int GPD_P1_WAKE_A = 0;
  localparam int GPD_P1_WAKE_B = 4;
  localparam int GPD_P2_CMP_N = 0;
  localparam int GPD_P2_CMP_P = 1;

  // Decoded view of the control register.
  typedef struct packed {
    logic sel14;
    logic sel10;
    logic extIrqEn;
    logic cmpDisable;
    logic floatSel;
  } gpd_ctrl_t;

endpackage : gpd_pkg

`default_nettype wire

// ==== tb/gpd_pin_model.sv ====
`default_nettype none

// Far side of one port: resolves each pin from the device drive,
// an outside driver and the internal pull-up.
module gpd_pin_model #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] pinOut,
  input wire logic [W-1:0] pinOe,
  input wire logic [W-1:0] pullEn,
  input wire logic [W-1:0] extVal,
  input wire logic [W-1:0] extOe,
  output logic [W-1:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // An undriven pin has no defined level, so it toggles every cycle.
  logic [W-1:0] noise = '0;

  // The toggle keeps a stale level from passing for a real one.
  always @(posedge clk) begin
    noise <= ~noise;
  end

  // Device drive wins, then the outside driver, then the pull-up.
  assign pinIn = (pinOe & pinOut) | (~pinOe & extOe & extVal) |
    (~pinOe & ~extOe & (pullEn | noise));
endmodule : gpd_pin_model

`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none

// Self-checking bench for the dual port, driven over APB.
module tb_top;
  import gpd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 0;
  logic rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic rmwAccess = 0;
  logic standbyMode = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, slvErr;
  logic [7:0] pinIn1, pinOut1, pinOe1, pullEn1, perIn1;
  logic [7:0] perOe1 = '0, perOut1 = '0, ext1 = '0;
  logic [3:0] pinIn2, pinOut2, pinOe2, pullEn2, perIn2;
  logic [3:0] perOe2 = '0, perOut2 = '0, ext2 = '0;
  logic [1:0] cmpInEn;
  // Register shadows, index 0 for port 1 and 1 for port 2.
  logic [7:0] shLat [2];
  logic [7:0] shDir [2];
  logic [7:0] shPul [2];
  int bad_count = 0;
  int num_checks = 0;

  always #2.5 clk = ~clk;

  gpd_dual_port u_gpd_dual_port (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rmwAccess(rmwAccess), .standbyMode(standbyMode), .pinIn1(pinIn1),
    .pinOut1(pinOut1), .pinOe1(pinOe1), .pullEn1(pullEn1), .perOe1(perOe1),
    .perOut1(perOut1), .perIn1(perIn1), .pinIn2(pinIn2), .pinOut2(pinOut2),
    .pinOe2(pinOe2), .pullEn2(pullEn2), .perOe2(perOe2), .perOut2(perOut2),
    .perIn2(perIn2), .cmpInEn(cmpInEn));

  // The outside world drives exactly the pins the device lets go.
  gpd_pin_model #(.W(8)) u_gpd_pin_model (.clk(clk), .pinOut(pinOut1),
    .pinOe(pinOe1), .pullEn(pullEn1), .extVal(ext1), .extOe(~pinOe1),
    .pinIn(pinIn1));
  gpd_pin_model #(.W(4)) u_gpd_pin_model_2 (.clk(clk), .pinOut(pinOut2),
    .pinOe(pinOe2), .pullEn(pullEn2), .extVal(ext2), .extOe(~pinOe2),
    .pinIn(pinIn2));

  // Counts one comparison and reports it at once if it differs.
  task automatic chk(input string name, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // One APB transfer; an idle edge first keeps back-to-back calls clean.
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic read_modify_write_access, output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    rmwAccess <= read_modify_write_access;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      tally_and_finish();
    end
    q = prdata;
    slvErr = pslverr;
    psel <= 0;
    penable <= 0;
    rmwAccess <= 0;
  endtask : apb

  // Drive value and enable of eight pins, from latch and peripheral.
  function automatic logic [15:0] pinExp(input logic [7:0] lat, dir, po,
      pv, od);
    logic [7:0] v;
    v = (po & pv) | (~po & lat);
    return {(dir | po) & ~(od & v), v};
  endfunction : pinExp

  // Checks one port's pins and both kinds of latch read.
  task automatic check_port(input int p);
    logic [7:0] wm, po, oe, v, pin, sel;
    logic [31:0] q;
    wm = p ? 8'h0f : 8'hff;
    po = p ? 8'(perOe2) : perOe1;
    {oe, v} = pinExp(shLat[p], shDir[p], po, p ? 8'(perOut2) : perOut1,
      p ? GPD_P2_OD_MASK : GPD_P1_OD_MASK);
    pin = (oe & v) | (~oe & (p ? 8'(ext2) : ext1));
    chk("pin enable", p ? 8'(pinOe2) : pinOe1, oe & wm);
    chk("pin value", (p ? 8'(pinOut2) : pinOut1) & oe, v & oe);
    chk("pull-up", p ? 8'(pullEn2) : pullEn1, shPul[p] & wm & ~(oe & ~v)
      & (p ? GPD_P2_PULL_MASK : GPD_P1_PULL_MASK));
    sel = shDir[p] & ~po;
    apb(0, p ? GPD_OFF_P2_LATCH : GPD_OFF_P1_LATCH, '0, 0, q);
    chk("plain read", q[7:0] & wm, ((sel & shLat[p]) | (~sel & pin)) & wm);
    apb(0, p ? GPD_OFF_P2_LATCH : GPD_OFF_P1_LATCH, '0, 1, q);
    chk("rmw read", q[7:0] & wm, shLat[p] & wm);
  endtask : check_port

  // Direction registers must come back cleared after every reset.
  task automatic check_reset();
    logic [31:0] q;
    apb(0, GPD_OFF_P1_DIR, '0, 0, q);
    chk("dir1 reset", q[7:0], GPD_RST_DIR);
    apb(0, GPD_OFF_P2_DIR, '0, 0, q);
    chk("dir2 reset", q[7:0], GPD_RST_DIR);
    chk("dir pins", pinOe1 | 8'(pinOe2), 8'h00);
    $display("test reset done");
  endtask : check_reset

  initial begin
    logic [31:0] q;
    logic [7:0] wm, po;
    gpd_ctrl_t ctl;
    void'($urandom(33));
    repeat (12) @(posedge clk);
    rst_n <= 1;
    check_reset();
    // Random setups, the first two all-ones and all-zero latch corners.
    for (int i = 0; i < 24; i++) begin
      for (int p = 0; p < 2; p++) begin
        wm = p ? 8'h0f : 8'hff;
        shLat[p] = (i < 2) ? (i ? 8'h00 : wm) : 8'($urandom()) & wm;
        shDir[p] = (i < 2) ? wm : 8'($urandom()) & wm;
        shPul[p] = (i < 2) ? wm : 8'($urandom()) & wm;
        po = (i > 11) ? 8'($urandom()) & wm : 8'h00;
        shDir[p] = shDir[p] & ~po;
        if (p == 0) begin
          perOe1 <= po;
          perOut1 <= 8'($urandom());
          ext1 <= 8'($urandom());
        end else begin
          perOe2 <= po[3:0];
          perOut2 <= 4'($urandom());
          ext2 <= 4'($urandom());
        end
        apb(1, p ? GPD_OFF_P2_LATCH : GPD_OFF_P1_LATCH, 32'(shLat[p]), 0, q);
        apb(1, p ? GPD_OFF_P2_DIR : GPD_OFF_P1_DIR, 32'(shDir[p]), 0, q);
        apb(1, p ? GPD_OFF_P2_PULL : GPD_OFF_P1_PULL, 32'(shPul[p]), 0, q);
      end
      repeat (3) @(posedge clk);
      check_port(0);
      check_port(1);
    end
    $display("test random pins done");
    // Floated standby keeps only the two selected wake pins open.
    ext1 <= 8'hff;
    ext2 <= 4'hf;
    ctl = '0;
    ctl.floatSel = 1;
    ctl.extIrqEn = 1;
    ctl.sel10 = 1;
    ctl.sel14 = 1;
    apb(1, GPD_OFF_CTRL, 32'(ctl), 0, q);
    standbyMode <= 1;
    repeat (5) @(posedge clk);
    chk("float enable", pinOe1 | 8'(pinOe2), 8'h00);
    chk("wake input", perIn1, 8'h11);
    chk("blocked input", 8'(perIn2), 8'h00);
    standbyMode <= 0;
    ctl.floatSel = 0;
    apb(1, GPD_OFF_CTRL, 32'(ctl), 0, q);
    standbyMode <= 1;
    repeat (5) @(posedge clk);
    check_port(0);
    check_port(1);
    standbyMode <= 0;
    $display("test standby done");
    // Comparator input follows its disable bit both ways.
    for (int b = 1; b >= 0; b--) begin
      ctl.cmpDisable = b[0];
      apb(1, GPD_OFF_CTRL, 32'(ctl), 0, q);
      repeat (2) @(posedge clk);
      chk("comparator", 8'(cmpInEn), b ? 8'h00 : 8'h03);
    end
    apb(0, 8'h1c, '0, 0, q);
    chk("unmapped", {7'h0, slvErr} | q[7:0] | 8'(|q[31:8]), 8'h01);
    $display("test comparator and unmapped done");
    // Peripherals let go so that only the direction bits could drive pins.
    perOe1 <= '0;
    perOe2 <= '0;
    @(posedge clk);
    rst_n <= 0;
    @(posedge clk);
    rst_n <= 1;
    check_reset();
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
